// file: logic/tak_pkg.sv
// Constants, enumerations and carriers of the texel address, key and shadow unit.
// Assumes one 40 MHz clock, a synchronous active-low reset and a plain register port.
// Functional notes
// - Repeat mode keeps only the coordinate fraction.
// - Coordinates are used directly, never shortest-path.
// - Single flip takes magnitude, clamps at one.
// - Edge hold returns the edge texel off-map.
// - Edge hold on cubes stays on one face.
// - Edge color substitutes border colour off-map, non-cube.
// - Face cross moves sample onto the adjoining face.
// - Fetch from memory or cache; flush invalidates.
// - Packed formats are expanded to colour automatically.
// - Palette formats look fetched index up in palette.
// - Four channels compared against inclusive bounds; all.
// - Key test only when sampler key enable set.
// - Discard action kills pixel on any match.
// - Zero action replaces matching sample with zeros.
// - Unreferenced samplers never match the key, never kill.
// - Compare requests test each sample against reference.
// - Compare outputs zero when relation holds, else one.
// - Compare result replaces the texel value downstream.
// - Compare uses the single channel only.
// - Flip mode reverses direction on odd intervals.
// - Each axis has its own addressing mode.
// - Edge half gives halfway edge and border.
package tak_pkg;
    // Register offsets (byte addresses).
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_KEY_LOW  = 8'h04;
    localparam logic [7:0] REG_KEY_HIGH = 8'h08;
    localparam logic [7:0] REG_BORDER   = 8'h0c;
    localparam logic [7:0] REG_TEX_BASE = 8'h10;
    localparam logic [7:0] REG_STATUS   = 8'h14;
    localparam logic [7:0] REG_FLUSH    = 8'h18;
    localparam logic [1:0] REG_PAL_PAGE = 2'h1;     // Offsets 0x40 to 0x7c hold the palette.
    // Field positions.
    localparam int CTRL_KEY_ON_BIT  = 0;
    localparam int CTRL_KEY_ACT_BIT = 1;
    localparam int CTRL_CMP_LSB     = 2;
    localparam int FLUSH_SCI_BIT    = 0;
    localparam int FLUSH_RCF_BIT    = 1;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_CVALID_BIT  = 1;
    localparam int STAT_KILL_BIT    = 2;
    // Reset values.
    localparam logic [31:0] KEY_LOW_RST  = 32'hffffffff;
    localparam logic [31:0] KEY_HIGH_RST = 32'h00000000;
    localparam logic [31:0] BORDER_RST   = 32'h00000000;
    localparam logic [31:0] BASE_RST     = 32'h00000000;
    // Coordinate and result constants (coordinates are signed 8.8 fixed point).
    localparam logic [7:0]  FRAC_MAX   = 8'hff;
    localparam logic [7:0]  CMP_ZERO   = 8'h00;
    localparam logic [7:0]  CMP_ONE    = 8'hff;
    localparam logic [7:0]  ALPHA_FULL = 8'hff;
    // Face reached on crossing, three bits per face, faces +x -x +y -y +z -z.
    localparam logic [17:0] CUBE_ADJ_XP = 18'h08025;
    localparam logic [17:0] CUBE_ADJ_XN = 18'h0126c;
    localparam logic [17:0] CUBE_ADJ_YP = 18'h1bb1b;
    localparam logic [17:0] CUBE_ADJ_YN = 18'h12952;

    typedef enum logic [2:0] {
        addr_mode_repeat      = 3'h0,
        addr_mode_flip        = 3'h1,
        addr_mode_face_cross  = 3'h2,
        addr_mode_edge_hold   = 3'h3,
        addr_mode_edge_color  = 3'h4,
        addr_mode_edge_half   = 3'h5,
        addr_mode_flip_single = 3'h6
    } tak_addr_mode_type;

    typedef enum logic [1:0] {
        FMT_RAW = 2'h0, FMT_PACKED565 = 2'h1, FMT_PALETTE = 2'h2
    } tak_fmt_type;

    typedef enum logic [2:0] {
        cmp_func_const_zero = 3'h0, cmp_func_const_one = 3'h1,
        cmp_func_lt = 3'h2, cmp_func_eq = 3'h3, cmp_func_le = 3'h4,
        cmp_func_gt = 3'h5, cmp_func_ne = 3'h6, cmp_func_ge = 3'h7
    } tak_cmp_func_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_DONE = 2'b11
    } tak_state_type;

    typedef struct packed {
        logic [15:0]       coord_x;
        logic [15:0]       coord_y;
        logic [15:0]       coord_z;
        tak_addr_mode_type mode_x;
        tak_addr_mode_type mode_y;
        tak_addr_mode_type mode_z;
        logic              is_cube;
        logic [2:0]        face;
        tak_fmt_type       fmt;
        logic              cmp_en;
        logic [7:0]        ref_val;
        logic              referenced;
    } tak_req_type;

    typedef struct packed {
        logic [31:0] texel;
        logic        kill;
        logic        key_match;
    } tak_res_type;
endpackage

// file: logic/tak_unit.sv
// Texel address, fetch, key and shadow compare unit: one sample per request.
// Assumes a memory port that answers each held request with one data-valid pulse.
`timescale 1ns/100ps
`default_nettype none
module tak_unit
    import tak_pkg::*;
(
    input  wire logic        i_clk_sys,      // System clock, 40 MHz.
    input  wire logic        i_nrst,         // Synchronous reset, active low.
    input  wire logic [7:0]  i_reg_addr,     // Register byte address.
    input  wire logic [31:0] i_reg_wdata,    // Register write data.
    input  wire logic        i_reg_wr,       // Register write strobe.
    input  wire logic        i_reg_rd,       // Register read strobe.
    output logic      [31:0] o_reg_rdata,    // Read data, valid the cycle after the strobe.
    input  wire logic        i_req_valid,    // Sample request strobe.
    input  wire tak_req_type i_req,          // Sample request.
    output logic             o_busy,         // A request is in flight.
    output logic             o_res_valid,    // Result strobe.
    output tak_res_type      o_res,          // Result texel and kill flag.
    output logic             o_mem_req,      // Memory read request, held until answered.
    output logic      [31:0] o_mem_addr,     // Memory word byte address.
    input  wire logic        i_mem_valid,    // Memory data strobe.
    input  wire logic [31:0] i_mem_data      // Memory data.
);

    // The state of the unit, all but the palette.
    typedef struct packed {
        tak_state_type    st;
        tak_req_type      req;
        logic             key_on;
        logic             key_act;
        tak_cmp_func_type cmp_func;
        logic [31:0]      key_low;
        logic [31:0]      key_high;
        logic [31:0]      border;
        logic [31:0]      tex_base;
        logic [3:0]       idx_x;
        logic [3:0]       idx_y;
        logic [3:0]       idx_z;
        logic             off_map;
        logic             half;
        logic             mem_req;
        logic [31:0]      mem_addr;
        logic             cache_valid;
        logic [31:0]      cache_addr;
        logic [31:0]      cache_data;
        logic [31:0]      rd_data;
        logic             res_valid;
        tak_res_type      res;
        logic             busy;
    } tak_vars_type;

    tak_vars_type q;                   // Registered state.
    tak_vars_type d;                   // Next state.
    logic [31:0]  palette [16];        // Palette table, written by software.
    logic [31:0]  word;                // Word fetched for the sample.
    logic [15:0]  half565;             // Selected packed texel.
    logic [31:0]  dec;                 // Decoded texel.
    logic [31:0]  samp;                // Texel after off-map substitution.
    logic [3:0]   ch_ok;               // Per-channel key range hits.
    logic         key_live;            // Key test active for this sample.
    logic         key_hit;             // All channels inside the key range.
    logic [31:0]  keyed;               // Texel after the key action.
    logic         rel;                 // Shadow relation result.
    logic [31:0]  final_texel;         // Texel sent out.
    logic         cache_hit;           // Fetch address held in the cache.

    // Maps one coordinate: returns {off_map, crossing, fraction}.
    function automatic logic [9:0] tak_map_axis(input logic [15:0] c, input tak_addr_mode_type m);
        logic       in_rng;
        logic [15:0] mag;
        logic [7:0] clamp_f;
        logic [9:0] r;
        in_rng  = (c[15:8] == 8'h00);
        mag     = c[15] ? (~c + 16'h0001) : c;
        clamp_f = c[15] ? 8'h00 : (in_rng ? c[7:0] : FRAC_MAX);
        case (m)
            addr_mode_repeat: begin
                // Integer part dropped; the coordinate is used as given, not shortest-path.
                r = {2'b00, c[7:0]};
            end
            addr_mode_flip: begin
                // Odd integer intervals run backwards.
                r = {2'b00, (c[8] ? ~c[7:0] : c[7:0])};
            end
            addr_mode_flip_single: begin
                // Magnitude first, then clamped at one.
                r = {2'b00, ((mag[15:8] != 8'h00) ? FRAC_MAX : mag[7:0])};
            end
            addr_mode_edge_color, addr_mode_edge_half: begin
                // Off-map samples are flagged for substitution.
                r = {~in_rng, 1'b0, clamp_f};
            end
            addr_mode_face_cross: begin
                // Crossing is flagged; the fraction lands on the next face.
                r = {1'b0, ~in_rng, c[7:0]};
            end
            default: begin
                // Edge hold repeats the edge texel.
                r = {2'b00, clamp_f};
            end
        endcase
        // In-range values leave every branch as their own fraction.
        return r;
    endfunction

    // Picks the face reached when a sample leaves the face it was on.
    function automatic logic [2:0] tak_next_face(input logic [17:0] tbl, input logic [2:0] f);
        return tbl[3 * f +: 3];
    endfunction

    // Word to decode: the memory answer while a read is open, else the cache.
    assign word      = q.mem_req ? i_mem_data : q.cache_data;
    assign cache_hit = q.cache_valid && (q.cache_addr == q.mem_addr);
    assign half565   = q.idx_x[0] ? word[31:16] : word[15:0];

    // Format decode, done without any request from the sampler side.
    always_comb begin
        case (q.req.fmt)
            FMT_PACKED565: begin
                // Five and six bit fields widened by repeating their top bits.
                dec = {ALPHA_FULL, half565[15:11], half565[15:13], half565[10:5], half565[10:9],
                       half565[4:0], half565[4:2]};
            end
            FMT_PALETTE: begin
                // The fetched value indexes the palette.
                dec = palette[word[3:0]];
            end
            default: begin
                dec = word;
            end
        endcase
    end

    // Per-channel border substitution and key range test.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            logic [8:0] sum;           // Edge plus border.
            assign sum = {1'b0, dec[8*gi +: 8]} + {1'b0, q.border[8*gi +: 8]};
            // Off-map: border colour, or the halfway value in half mode.
            assign samp[8*gi +: 8] = !q.off_map ? dec[8*gi +: 8] :
                                     (q.half ? sum[8:1] : q.border[8*gi +: 8]);
            // Inclusive bounds, each channel on its own.
            assign ch_ok[gi] = (samp[8*gi +: 8] >= q.key_low[8*gi +: 8]) &&
                               (samp[8*gi +: 8] <= q.key_high[8*gi +: 8]);
        end
    endgenerate

    // Key action and shadow compare on the fetched sample, ahead of any filter.
    always_comb begin
        key_hit  = &ch_ok;
        key_live = q.key_on && q.req.referenced;
        keyed    = (key_live && q.key_act && key_hit) ? 32'h00000000 : samp;
        // Only the single stored channel takes part in the compare.
        case (q.cmp_func)
            cmp_func_const_zero: rel = 1'b1;
            cmp_func_const_one:  rel = 1'b0;
            cmp_func_lt:         rel = keyed[7:0] <  q.req.ref_val;
            cmp_func_eq:         rel = keyed[7:0] == q.req.ref_val;
            cmp_func_le:         rel = keyed[7:0] <= q.req.ref_val;
            cmp_func_gt:         rel = keyed[7:0] >  q.req.ref_val;
            cmp_func_ne:         rel = keyed[7:0] != q.req.ref_val;
            default:             rel = keyed[7:0] >= q.req.ref_val;
        endcase
        // Zero when the relation holds, one otherwise, replacing the texel.
        final_texel = q.req.cmp_en ? {24'h000000, (rel ? CMP_ZERO : CMP_ONE)} : keyed;
    end

    // Next-state logic: register port, request acceptance, fetch and result.
    always_comb begin
        logic [9:0]  mx;
        logic [9:0]  my;
        logic [9:0]  mz;
        logic [2:0]  nf;
        logic [3:0]  slice;
        logic [3:0]  xi;
        mx    = 10'h000;
        my    = 10'h000;
        mz    = 10'h000;
        nf    = 3'h0;
        slice = 4'h0;
        xi    = 4'h0;
        d           = q;
        d.rd_data   = 32'h00000000;
        d.res_valid = 1'b0;

        // Register writes.
        if (i_reg_wr) begin
            case (i_reg_addr)
                REG_CTRL: begin
                    d.key_on   = i_reg_wdata[CTRL_KEY_ON_BIT];
                    d.key_act  = i_reg_wdata[CTRL_KEY_ACT_BIT];
                    d.cmp_func = tak_cmp_func_type'(i_reg_wdata[CTRL_CMP_LSB +: 3]);
                end
                REG_KEY_LOW:  d.key_low  = i_reg_wdata;
                REG_KEY_HIGH: d.key_high = i_reg_wdata;
                REG_BORDER:   d.border   = i_reg_wdata;
                REG_TEX_BASE: d.tex_base = i_reg_wdata;
                REG_FLUSH: begin
                    // Either flush field drops the cached word.
                    if (i_reg_wdata[FLUSH_SCI_BIT] || i_reg_wdata[FLUSH_RCF_BIT]) begin
                        d.cache_valid = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped offsets read zero.
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_CTRL:     d.rd_data = {27'h0000000, q.cmp_func, q.key_act, q.key_on};
                REG_KEY_LOW:  d.rd_data = q.key_low;
                REG_KEY_HIGH: d.rd_data = q.key_high;
                REG_BORDER:   d.rd_data = q.border;
                REG_TEX_BASE: d.rd_data = q.tex_base;
                REG_STATUS:   d.rd_data = {29'h00000000, q.res.kill, q.cache_valid, q.busy};
                default: begin
                    if (i_reg_addr[7:6] == REG_PAL_PAGE) begin
                        d.rd_data = palette[i_reg_addr[5:2]];
                    end
                end
            endcase
        end

        case (q.st)
            ST_IDLE: begin
                if (i_req_valid) begin
                    // Each axis mapped under its own mode before the address is formed.
                    mx = tak_map_axis(i_req.coord_x, i_req.mode_x);
                    my = tak_map_axis(i_req.coord_y, i_req.mode_y);
                    mz = tak_map_axis(i_req.coord_z, i_req.mode_z);
                    nf = i_req.face;
                    if (i_req.is_cube && mx[8]) begin
                        nf = tak_next_face(i_req.coord_x[15] ? CUBE_ADJ_XN : CUBE_ADJ_XP, i_req.face);
                    end else if (i_req.is_cube && my[8]) begin
                        nf = tak_next_face(i_req.coord_y[15] ? CUBE_ADJ_YN : CUBE_ADJ_YP, i_req.face);
                    end
                    d.req     = i_req;
                    d.idx_x   = mx[7:4];
                    d.idx_y   = my[7:4];
                    d.idx_z   = mz[7:4];
                    // Cubes never take the border; edge modes stay on the face.
                    d.off_map = !i_req.is_cube && (mx[9] || my[9] || mz[9]);
                    d.half    = (i_req.mode_x == addr_mode_edge_half) || (i_req.mode_y == addr_mode_edge_half) ||
                                (i_req.mode_z == addr_mode_edge_half);
                    slice     = i_req.is_cube ? {1'b0, nf} : mz[7:4];
                    xi        = (i_req.fmt == FMT_PACKED565) ? {1'b0, mx[7:5]} : mx[7:4];
                    d.mem_addr = q.tex_base + {18'h00000, slice, my[7:4], xi, 2'b00};
                    d.st      = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (q.mem_req && i_mem_valid) begin
                    // Memory answer: fill the cache, this set beats a flush in the same cycle.
                    d.mem_req     = 1'b0;
                    d.cache_valid = 1'b1;
                    d.cache_addr  = q.mem_addr;
                    d.cache_data  = i_mem_data;
                    d.res         = '{texel: final_texel, kill: key_live && !q.key_act && key_hit,
                                      key_match: key_live && key_hit};
                    d.res_valid   = 1'b1;
                    d.st          = ST_DONE;
                end else if (!q.mem_req && cache_hit) begin
                    // Cached word serves the sample without a memory read.
                    d.res       = '{texel: final_texel, kill: key_live && !q.key_act && key_hit,
                                    key_match: key_live && key_hit};
                    d.res_valid = 1'b1;
                    d.st        = ST_DONE;
                end else begin
                    d.mem_req = 1'b1;
                end
            end
            ST_DONE: begin
                d.st = ST_IDLE;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.busy = (d.st != ST_IDLE);
    end

    // State register with synchronous reset.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.key_low  <= KEY_LOW_RST;
            q.key_high <= KEY_HIGH_RST;
            q.border   <= BORDER_RST;
            q.tex_base <= BASE_RST;
        end else begin
            q <= d;
        end
    end

    // Palette storage, loaded through the register page.
    always_ff @(posedge i_clk_sys) begin
        if (i_reg_wr && (i_reg_addr[7:6] == REG_PAL_PAGE)) begin
            palette[i_reg_addr[5:2]] <= i_reg_wdata;
        end
    end

    // Outputs straight from the state register.
    assign o_reg_rdata = q.rd_data;
    assign o_busy      = q.busy;
    assign o_res_valid = q.res_valid;
    assign o_res       = q.res;
    assign o_mem_req   = q.mem_req;
    assign o_mem_addr  = q.mem_addr;

    // Checks on the unit's own behaviour.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    // A request is accepted in idle and the mapping is ready the next cycle.
    sequence s_accept;
        i_req_valid && !o_busy;
    endsequence
    // A result is delivered for a compare request.
    sequence s_cmp_result;
        o_res_valid && q.req.cmp_en;
    endsequence

    a_repeat_frac_x: assert property (s_accept and i_req.mode_x == addr_mode_repeat
        |=> q.idx_x == $past(i_req.coord_x[7:4]) && o_busy)
        else $error("repeat mode index is not the fraction");
    a_flip_odd_x: assert property (s_accept and i_req.mode_x == addr_mode_flip && i_req.coord_x[8]
        |=> q.idx_x == ~$past(i_req.coord_x[7:4]))
        else $error("flip mode did not reverse on odd interval");
    a_cube_no_border: assert property (s_accept and i_req.is_cube |=> !q.off_map)
        else $error("cube sample took the border path");
    a_cmp_binary_out: assert property (s_cmp_result |-> o_res.texel == 32'h00000000 ||
        o_res.texel == {24'h000000, CMP_ONE})
        else $error("compare result is not zero or one");
    a_unref_no_kill: assert property (o_res_valid && !q.req.referenced |-> !o_res.kill && !o_res.key_match)
        else $error("unreferenced sampler killed or matched");
    a_key_off_no_kill: assert property (o_res_valid && !q.key_on |-> !o_res.kill)
        else $error("kill while key test disabled");
    a_zero_replace: assert property (o_res_valid && o_res.key_match && q.key_act && !q.req.cmp_en
        |-> o_res.texel == 32'h00000000 && !o_res.kill)
        else $error("matching sample not replaced with zero");
    a_flush_drops: assert property (i_reg_wr && i_reg_addr == REG_FLUSH && (i_reg_wdata[FLUSH_SCI_BIT] ||
        i_reg_wdata[FLUSH_RCF_BIT]) && !(q.mem_req && i_mem_valid) |=> !q.cache_valid)
        else $error("flush left the cache valid");
    a_mem_hold: assert property (o_mem_req && !i_mem_valid |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request dropped before answer");
    a_result_pulse: assert property (o_res_valid |=> !o_res_valid && !o_busy)
        else $error("result strobe longer than one cycle");
    a_read_slot: assert property (!i_reg_rd |=> o_reg_rdata == 32'h00000000)
        else $error("read data outside its slot");

endmodule
`default_nettype wire

// file: verification/tak_mem_model.sv
// Texture memory model on the fetch port of the unit.
// Assumes the unit holds its request until it sees the data strobe.
`timescale 1ns/100ps
`default_nettype none
module tak_mem_model (
    input  wire logic        i_clk_sys, // System clock.
    input  wire logic        i_req,     // Held read request.
    input  wire logic [31:0] i_addr,    // Word byte address.
    input  wire logic [3:0]  i_delay,   // Wait cycles before answering.
    output logic             o_valid,   // One-cycle data strobe.
    output logic      [31:0] o_data     // Word, noise outside the strobe.
);
    logic [3:0]  cnt_q;            // Cycles waited on this request.
    logic [31:0] noise_q = 32'h0;  // Changes each cycle so stale data never matches.
    // Answers after the set wait with a word made from the address.
    always_ff @(posedge i_clk_sys) begin
        o_valid <= 1'b0;
        noise_q <= noise_q + 32'h9e3779b9;
        o_data  <= noise_q;
        cnt_q   <= 4'h0;
        if (i_req && !o_valid && cnt_q == i_delay) begin
            o_valid <= 1'b1;
            o_data  <= i_addr ^ 32'h5a5a0000;
        end else if (i_req && !o_valid) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the texel address, key and shadow unit.
// Assumes the memory model stands on the fetch port; word = address ^ 5a5a0000.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tak_pkg::*;
    // One case: control (bit 5 asks for compare), x, mode, reference, texel, kill.
    typedef struct packed {
        logic [5:0]        ctrl;
        logic [15:0]       x;
        tak_addr_mode_type m;
        logic [7:0]        rf;
        logic [31:0]       t;
        logic              k;
    } tak_row_type;
    logic        i_clk_sys = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_req_valid = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, o_mem_addr, i_mem_data;
    logic        o_busy, o_res_valid, o_mem_req, i_mem_valid;
    tak_req_type i_req = '0, ex = '0;
    tak_res_type o_res;
    tak_row_type w;
    int          failures = 0, samples_checked = 0;
    // Base is 1000, border 11223344; index 5 word 5a5a1014, 15 is 103c, 0 is 1000, 4 is 1010.
    tak_row_type rows [21] = '{
        '{6'h00, 16'h0350, addr_mode_repeat, 8'h00, 32'h5a5a1014, 1'b0},
        '{6'h00, 16'hfe50, addr_mode_repeat, 8'h00, 32'h5a5a1014, 1'b0},
        '{6'h00, 16'h0350, addr_mode_edge_hold, 8'h00, 32'h5a5a103c, 1'b0},
        '{6'h00, 16'hff80, addr_mode_edge_hold, 8'h00, 32'h5a5a1000, 1'b0},
        '{6'h00, 16'hffc0, addr_mode_flip_single, 8'h00, 32'h5a5a1010, 1'b0},
        '{6'h00, 16'h0200, addr_mode_flip_single, 8'h00, 32'h5a5a103c, 1'b0},
        '{6'h00, 16'h0340, addr_mode_flip, 8'h00, 32'h5a5a102c, 1'b0},
        '{6'h00, 16'h0350, addr_mode_edge_color, 8'h00, 32'h11223344, 1'b0},
        '{6'h00, 16'h0050, addr_mode_edge_color, 8'h00, 32'h5a5a1014, 1'b0},
        '{6'h01, 16'h0050, addr_mode_repeat, 8'h00, 32'h5a5a1014, 1'b1},
        '{6'h03, 16'h0050, addr_mode_repeat, 8'h00, 32'h00000000, 1'b0},
        '{6'h20, 16'h0050, addr_mode_repeat, 8'h14, 32'h00000000, 1'b0},
        '{6'h24, 16'h0050, addr_mode_repeat, 8'h14, 32'h000000ff, 1'b0},
        '{6'h28, 16'h0050, addr_mode_repeat, 8'h14, 32'h000000ff, 1'b0},
        '{6'h28, 16'h0050, addr_mode_repeat, 8'h15, 32'h00000000, 1'b0},
        '{6'h2c, 16'h0050, addr_mode_repeat, 8'h14, 32'h00000000, 1'b0},
        '{6'h30, 16'h0050, addr_mode_repeat, 8'h14, 32'h00000000, 1'b0},
        '{6'h34, 16'h0050, addr_mode_repeat, 8'h14, 32'h000000ff, 1'b0},
        '{6'h38, 16'h0050, addr_mode_repeat, 8'h14, 32'h000000ff, 1'b0},
        '{6'h3c, 16'h0050, addr_mode_repeat, 8'h14, 32'h00000000, 1'b0},
        '{6'h00, 16'h0350, addr_mode_edge_half, 8'h00, 32'h353e2140, 1'b0}};
    always #12.5 i_clk_sys = ~i_clk_sys;
    tak_unit tak_unit_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_busy(o_busy), .o_res_valid(o_res_valid), .o_res(o_res),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_valid(i_mem_valid), .i_mem_data(i_mem_data));
    tak_mem_model tak_mem_model_i (.i_clk_sys(i_clk_sys), .i_req(o_mem_req), .i_addr(o_mem_addr),
        .i_delay(4'(samples_checked % 3)), .o_valid(i_mem_valid), .o_data(i_mem_data));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are looked at there.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(o_reg_rdata, e);
    endtask
    // Sets the control word, issues one sample and checks the result pulse.
    task automatic smp(input tak_row_type r);
        tak_req_type q;
        q = ex;
        q.coord_x = r.x;
        q.mode_x = r.m;
        q.cmp_en = r.ctrl[5];
        q.ref_val = r.rf;
        wr(REG_CTRL, {27'h0, r.ctrl[4:0]});
        i_req_valid <= 1'b1;
        i_req <= q;
        @(posedge i_clk_sys);
        i_req_valid <= 1'b0;
        for (int n = 0; n < 40 && o_res_valid !== 1'b1; n++) @(negedge i_clk_sys);
        chk({30'h0, o_res_valid, o_res.kill}, {30'h0, 1'b1, r.k});
        chk(o_res.texel, r.t);
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run the usual way.
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        failures++;
        conclude();
    end
    initial begin
        ex.referenced = 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        wr(REG_TEX_BASE, 32'h1000);
        wr(REG_BORDER, 32'h11223344);
        wr(REG_KEY_LOW, 32'h0);
        wr(REG_KEY_HIGH, 32'hffffffff);
        wr(8'h50, 32'hffabcdef); // Palette entry four.
        for (int i = 0; i < 21; i++) begin
            smp(rows[i]);
        end
        w = rows[9];
        w.k = 1'b0;
        ex.referenced = 1'b0;
        smp(w);
        ex.referenced = 1'b1;
        ex.fmt = FMT_PALETTE;
        w = rows[0];
        w.t = 32'hffabcdef;
        smp(w);
        ex.fmt = FMT_RAW;
        ex.is_cube = 1'b1;
        ex.face = 3'h2;
        w = rows[2];
        w.t = 32'h5a5a183c;
        smp(w);
        w.m = addr_mode_face_cross;
        w.t = 32'h5a5a1014;
        smp(w);
        ex.is_cube = 1'b0;
        ex.mode_y = addr_mode_edge_hold;
        ex.coord_y = 16'h0350;
        w = rows[0];
        w.t = 32'h5a5a13d4;
        smp(w);
        ex.coord_y = 16'h0;
        wr(REG_KEY_LOW, 32'h5a5a1014);
        wr(REG_KEY_HIGH, 32'h5a5a1014);
        smp(rows[10]);
        wr(REG_KEY_LOW, 32'h5b5a1014);
        w = rows[10];
        w.t = 32'h5a5a1014;
        smp(w);
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        rd(REG_KEY_LOW, KEY_LOW_RST);
        rd(REG_KEY_HIGH, KEY_HIGH_RST);
        rd(REG_BORDER, BORDER_RST);
        rd(8'h20, 32'h0);
        wr(REG_TEX_BASE, 32'h1000);
        smp(rows[0]);
        rd(REG_STATUS, 32'h2);
        wr(REG_FLUSH, 32'h2);
        rd(REG_STATUS, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
